// >>> logic/sxo_core.sv
// execute unit for test-and-skip, xor literal, xor register and table write
// assumes the fetch path holds instr_word with instr_valid until instr_ready,
// data memory returns read data the cycle after dm_rd_en, and writes on dm_wr_en
// Functional notes
// - test-and-skip decoded from 0110011a ffffffff; flags stay untouched.
// - zero register discards prefetched word, runs a nop; two cycles total.
// - skip over a two-word instruction flushes both words; three cycles.
// - bank bit zero selects access bank, one selects bank by bank select.
// - bank bit zero, extension on, address at most 5fh: indexed offset mode.
// - xor literal: w xor immediate into w, only n and z change, one cycle.
// - xor register decoded from 000110da ffffffff; updates n and z; one cycle.
// - xor register result goes to w when d is zero, else to the register.
module sxo_core #(
    parameter int ADDR_W = 12,
    parameter int PTR_W  = 22
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              instr_valid,
    input  wire logic [15:0]       instr_word,
    input  wire logic              next_two_word,
    input  wire logic [ADDR_W-9:0] bank_select_reg,
    input  wire logic              ext_enable,
    input  wire logic [ADDR_W-1:0] index_base,
    input  wire logic [7:0]        dm_rd_data,
    input  wire logic [7:0]        table_latch,
    input  wire logic              ptr_load,
    input  wire logic [PTR_W-1:0]  ptr_load_val,
    output logic                   instr_ready,
    output logic                   instr_done,
    output logic                   flush_prefetch,
    output logic                   skip_active,
    output logic [ADDR_W-1:0]      dm_addr,
    output logic                   dm_rd_en,
    output logic                   dm_wr_en,
    output logic [7:0]             dm_wr_data,
    output logic [7:0]             w_value,
    output logic                   flag_n,
    output logic                   flag_z,
    output logic                   tbl_wr_en,
    output logic [PTR_W-1:0]       tbl_wr_addr,
    output logic [7:0]             tbl_wr_data,
    output logic [PTR_W-1:0]       table_pointer
);

    // ************************************************************
    // state and decode
    // ************************************************************
    sxo_pkg::sxo_state_t state_reg;
    sxo_pkg::sxo_state_t state_next;
    logic [1:0]          q_reg;
    logic [1:0]          skip_left_reg;
    logic [15:0]         ir_reg;
    logic [7:0]          result_reg;
    logic                ready_reg;

    wire logic            op_tst;
    wire logic            op_xor_reg_op;
    wire logic            op_xor_literal_op;
    wire logic            op_table_write_op;
    wire logic [1:0]      tbl_mode;
    wire logic            in_exec;
    wire logic            last_q;
    wire logic            skip_go;
    wire logic [7:0]      operand;
    wire logic [7:0]      xor_result;
    wire logic [ADDR_W-1:0] fa_addr;
    wire logic            fa_indexed;

    assign op_tst     = (ir_reg & sxo_pkg::MASK_TST) == sxo_pkg::PAT_TST;
    assign op_xor_reg_op   = (ir_reg & sxo_pkg::MASK_XOR_REG_OP) == sxo_pkg::PAT_XOR_REG_OP;
    assign op_xor_literal_op   = (ir_reg & sxo_pkg::MASK_XOR_LITERAL_OP) == sxo_pkg::PAT_XOR_LITERAL_OP;
    assign op_table_write_op   = (ir_reg & sxo_pkg::MASK_TABLE_WRITE_OP) == sxo_pkg::PAT_TABLE_WRITE_OP;
    assign tbl_mode   = ir_reg[1:0];
    assign in_exec    = state_reg == sxo_pkg::SXO_EXEC;
    assign last_q     = q_reg == sxo_pkg::Q4;
    // zero test result is latched in Q3 into result_reg
    assign skip_go    = op_tst && (result_reg == 8'h00);
    assign operand    = op_xor_literal_op ? ir_reg[7:0] : dm_rd_data;
    assign xor_result = op_tst ? dm_rd_data : (w_value ^ operand);

    sxo_addr #(
        .ADDR_W (ADDR_W)
    ) u_addr (
        .file_addr       (ir_reg[7:0]),
        .bank_bit        (ir_reg[sxo_pkg::BIT_BANK]),
        .bank_select_reg (bank_select_reg),
        .ext_enable      (ext_enable),
        .index_base      (index_base),
        .mem_addr        (fa_addr),
        .indexed         (fa_indexed)
    );

    // ************************************************************
    // sequencer
    // ************************************************************
    // each instruction cycle is four clocks, one per quarter phase
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            sxo_pkg::SXO_IDLE: begin
                if (instr_valid) state_next = sxo_pkg::SXO_EXEC;
            end
            sxo_pkg::SXO_EXEC: begin
                if (last_q && op_table_write_op) state_next = sxo_pkg::SXO_TBL2;
                else if (last_q && skip_go) state_next = sxo_pkg::SXO_SKIP;
                else if (last_q) state_next = sxo_pkg::SXO_IDLE;
            end
            sxo_pkg::SXO_TBL2: begin
                if (last_q) state_next = sxo_pkg::SXO_IDLE;
            end
            sxo_pkg::SXO_SKIP: begin
                if (last_q && skip_left_reg == sxo_pkg::SKIP_ONE) state_next = sxo_pkg::SXO_IDLE;
            end
            default: state_next = sxo_pkg::SXO_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= sxo_pkg::SXO_IDLE;
            q_reg     <= sxo_pkg::Q1;
        end else begin
            state_reg <= state_next;
            q_reg     <= (state_reg == sxo_pkg::SXO_IDLE) ? sxo_pkg::Q1 : q_reg + 2'h1;
        end
    end

    // handshake and status strobes, all registered
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ready_reg      <= 1'b1;
            instr_done     <= 1'b0;
            flush_prefetch <= 1'b0;
            skip_active    <= 1'b0;
            ir_reg         <= 16'h0000;
        end else begin
            ready_reg      <= state_next == sxo_pkg::SXO_IDLE;
            instr_done     <= state_reg != sxo_pkg::SXO_IDLE && state_next == sxo_pkg::SXO_IDLE;
            flush_prefetch <= in_exec && last_q && skip_go;
            skip_active    <= state_next == sxo_pkg::SXO_SKIP;
            if (state_reg == sxo_pkg::SXO_IDLE && instr_valid) ir_reg <= instr_word;
        end
    end
    assign instr_ready = ready_reg;

    // two-word follower costs one more flushed cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            skip_left_reg <= 2'h0;
        end else if (in_exec && last_q) begin
            skip_left_reg <= next_two_word ? sxo_pkg::SKIP_TWO : sxo_pkg::SKIP_ONE;
        end else if (state_reg == sxo_pkg::SXO_SKIP && last_q) begin
            skip_left_reg <= skip_left_reg - 2'h1;
        end
    end

    // ************************************************************
    // data memory and working register
    // ************************************************************
    // address formed in Q1, read in Q2, processed in Q3, written in Q4
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dm_addr  <= '0;
            dm_rd_en <= 1'b0;
        end else begin
            if (in_exec && q_reg == sxo_pkg::Q1) dm_addr <= fa_addr;
            dm_rd_en <= in_exec && q_reg == sxo_pkg::Q1 && (op_tst || op_xor_reg_op);
        end
    end

    // test never writes; xor register writes back only with d set
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            result_reg <= 8'h00;
            dm_wr_en   <= 1'b0;
            dm_wr_data <= 8'h00;
        end else begin
            if (in_exec && q_reg == sxo_pkg::Q3) result_reg <= xor_result;
            dm_wr_en <= in_exec && q_reg == sxo_pkg::Q3 && op_xor_reg_op && ir_reg[sxo_pkg::BIT_DEST];
            if (in_exec && q_reg == sxo_pkg::Q3) dm_wr_data <= xor_result;
        end
    end

    // flags change in Q3 for the xor forms only
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag_n <= 1'b0;
            flag_z <= 1'b0;
        end else if (in_exec && q_reg == sxo_pkg::Q3 && (op_xor_literal_op || op_xor_reg_op)) begin
            flag_n <= xor_result[7];
            flag_z <= xor_result == 8'h00;
        end
    end

    // w is written in Q4
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            w_value <= 8'h00;
        end else if (in_exec && last_q && (op_xor_literal_op || (op_xor_reg_op && !ir_reg[sxo_pkg::BIT_DEST]))) begin
            w_value <= result_reg;
        end
    end

    // ************************************************************
    // table write
    // ************************************************************
    // pointer load is taken only while idle so it cannot race an update
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            table_pointer <= '0;
        end else if (state_reg == sxo_pkg::SXO_IDLE && ptr_load) begin
            table_pointer <= ptr_load_val;
        end else if (in_exec && q_reg == sxo_pkg::Q1 && op_table_write_op && tbl_mode == sxo_pkg::TBL_PREI) begin
            table_pointer <= table_pointer + PTR_W'(1);
        end else if (state_reg == sxo_pkg::SXO_TBL2 && last_q) begin
            if (tbl_mode == sxo_pkg::TBL_POSTI) table_pointer <= table_pointer + PTR_W'(1);
            if (tbl_mode == sxo_pkg::TBL_POSTD) table_pointer <= table_pointer - PTR_W'(1);
        end
    end

    // holding register write in Q4 of the second cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tbl_wr_en   <= 1'b0;
            tbl_wr_addr <= '0;
            tbl_wr_data <= 8'h00;
        end else begin
            tbl_wr_en <= state_reg == sxo_pkg::SXO_TBL2 && q_reg == sxo_pkg::Q3;
            if (state_reg == sxo_pkg::SXO_TBL2 && q_reg == sxo_pkg::Q3) begin
                tbl_wr_addr <= table_pointer;
                tbl_wr_data <= table_latch;
            end
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_TST_FLAGS: assert property (in_exec && q_reg == sxo_pkg::Q3 && op_tst
        |=> $stable(flag_n) && $stable(flag_z)) else $error("test changed flags");
    AST_SKIP_ONE: assert property (in_exec && last_q && skip_go && !next_two_word
        |=> skip_active [*4] ##1 !skip_active && instr_done)
        else $error("single skip length wrong");
    AST_SKIP_TWO: assert property (in_exec && last_q && skip_go && next_two_word
        |=> skip_active [*8] ##1 !skip_active && instr_done)
        else $error("double skip length wrong");
    AST_BANKED: assert property (in_exec && q_reg == sxo_pkg::Q1 && op_xor_reg_op
        && ir_reg[sxo_pkg::BIT_BANK]
        |=> dm_addr == {$past(bank_select_reg), $past(ir_reg[7:0])})
        else $error("banked address wrong");
    // indexed condition restated here so a broken address former cannot hide it
    AST_INDEXED: assert property (in_exec && q_reg == sxo_pkg::Q1 && !ir_reg[sxo_pkg::BIT_BANK]
        && ext_enable && ir_reg[7:0] <= sxo_pkg::ILO_LIMIT
        |=> dm_addr == $past(index_base) + ADDR_W'($past(ir_reg[7:0])))
        else $error("indexed address wrong");
    AST_TST_PHASES: assert property (in_exec && q_reg == sxo_pkg::Q1 && op_tst
        |=> dm_rd_en ##1 !dm_rd_en ##1 !dm_wr_en) else $error("test phase order wrong");
    AST_XOR_LITERAL_OP: assert property (in_exec && q_reg == sxo_pkg::Q3 && op_xor_literal_op
        |=> ##1 w_value == ($past(w_value, 2) ^ $past(ir_reg[7:0], 2)) && instr_done)
        else $error("xor literal result wrong");
    AST_XOR_REG_OP_CYC: assert property (in_exec && q_reg == sxo_pkg::Q1 && op_xor_reg_op
        |-> ##4 instr_done) else $error("xor register not one cycle");
    AST_DEST: assert property (in_exec && q_reg == sxo_pkg::Q3 && op_xor_reg_op
        |=> dm_wr_en == ir_reg[sxo_pkg::BIT_DEST] && dm_wr_data == $past(w_value ^ operand))
        else $error("xor destination wrong");
    AST_TBL_POST: assert property (tbl_wr_en && tbl_mode == sxo_pkg::TBL_POSTI
        |=> table_pointer == $past(tbl_wr_addr) + PTR_W'(1)) else $error("post increment wrong");
    AST_FLAGS: assert property (in_exec && q_reg == sxo_pkg::Q3 && (op_xor_literal_op || op_xor_reg_op)
        |=> flag_z == ($past(w_value ^ operand) == 8'h00)
        && flag_n == $past(w_value[7] ^ operand[7])) else $error("flags wrong");

    COV_SKIP_ONE: cover property (flush_prefetch && skip_left_reg == sxo_pkg::SKIP_ONE);
    COV_SKIP_TWO: cover property (flush_prefetch && skip_left_reg == sxo_pkg::SKIP_TWO);
    COV_XOR_MEM: cover property (dm_wr_en);
    COV_TBL_PRE: cover property (tbl_wr_en && tbl_mode == sxo_pkg::TBL_PREI);

endmodule

// >>> logic/sxo_pkg.sv
// constants for the skip-test / exclusive-or / table-write execute unit
// assumes one clk, async active-high reset, 8-bit data, 16-bit instruction words
package sxo_pkg;

    // ************************************************************
    // opcode masks and patterns
    // ************************************************************
    localparam logic [15:0] MASK_TST   = 16'hfe00; // test reg, skip if zero
    localparam logic [15:0] PAT_TST    = 16'h6600;
    localparam logic [15:0] MASK_XOR_REG_OP = 16'hfc00; // xor w with register
    localparam logic [15:0] PAT_XOR_REG_OP  = 16'h1800;
    localparam logic [15:0] MASK_XOR_LITERAL_OP = 16'hff00; // xor w with literal
    localparam logic [15:0] PAT_XOR_LITERAL_OP  = 16'h0a00;
    localparam logic [15:0] MASK_TABLE_WRITE_OP = 16'hfffc; // table write family
    localparam logic [15:0] PAT_TABLE_WRITE_OP  = 16'h000c;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int BIT_DEST = 9;
    localparam int BIT_BANK = 8;

    // table write pointer modes (low two opcode bits)
    localparam logic [1:0] TBL_PLAIN = 2'h0;
    localparam logic [1:0] TBL_POSTI = 2'h1;
    localparam logic [1:0] TBL_POSTD = 2'h2;
    localparam logic [1:0] TBL_PREI  = 2'h3;

    // ************************************************************
    // addressing constants
    // ************************************************************
    localparam logic [7:0] ACC_SPLIT = 8'h80; // access bank low/high split
    localparam logic [7:0] ILO_LIMIT = 8'h5f; // indexed offset upper bound
    localparam logic [3:0] ACC_HIGH  = 4'hf;  // bank of the high access half
    localparam logic [3:0] ACC_LOW   = 4'h0;

    // ************************************************************
    // quarter phases and sequencer
    // ************************************************************
    localparam logic [1:0] Q1 = 2'h0;
    localparam logic [1:0] Q2 = 2'h1;
    localparam logic [1:0] Q3 = 2'h2;
    localparam logic [1:0] Q4 = 2'h3;
    localparam logic [1:0] SKIP_ONE = 2'h1; // flushed words after a skip
    localparam logic [1:0] SKIP_TWO = 2'h2;

    typedef enum logic [1:0] {
        SXO_IDLE = 2'b00,
        SXO_EXEC = 2'b01,
        SXO_TBL2 = 2'b10,
        SXO_SKIP = 2'b11
    } sxo_state_t;

endpackage

// >>> logic/sxo_addr.sv
// data memory address former for file-register operands
// assumes bank select and index base are stable while an operand is formed
module sxo_addr #(
    parameter int ADDR_W = 12
) (
    input  wire logic [7:0]        file_addr,
    input  wire logic              bank_bit,
    input  wire logic [ADDR_W-9:0] bank_select_reg,
    input  wire logic              ext_enable,
    input  wire logic [ADDR_W-1:0] index_base,
    output wire logic [ADDR_W-1:0] mem_addr,
    output wire logic              indexed
);

    // ************************************************************
    // bank selection
    // ************************************************************
    wire logic [ADDR_W-9:0] acc_bank;
    wire logic [ADDR_W-1:0] banked;
    wire logic [ADDR_W-1:0] idx_sum;

    // low half of the access bank maps to bank 0, high half to the top bank
    assign acc_bank = (file_addr < sxo_pkg::ACC_SPLIT) ? (ADDR_W-8)'(sxo_pkg::ACC_LOW)
                                                       : (ADDR_W-8)'(sxo_pkg::ACC_HIGH);
    assign banked   = bank_bit ? {bank_select_reg, file_addr} : {acc_bank, file_addr};
    // indexed offset only reaches the low access half, so the sum is a plain add
    assign indexed  = !bank_bit && ext_enable && (file_addr <= sxo_pkg::ILO_LIMIT);
    assign idx_sum  = index_base + ADDR_W'(file_addr);
    assign mem_addr = indexed ? idx_sum : banked;

endmodule

// >>> tb/sxo_dmem.sv
// data memory model standing behind the execute unit's data port
// assumes dm_rd_en and dm_wr_en are one-cycle pulses sampled on rising clk
module sxo_dmem (
    input  wire logic        clk,
    input  wire logic [11:0] dm_addr,
    input  wire logic        dm_rd_en,
    input  wire logic        dm_wr_en,
    input  wire logic [7:0]  dm_wr_data,
    output logic [7:0]       dm_rd_data
);
    timeunit 1ns;
    timeprecision 100ps;

    // ************************************************************
    // storage
    // ************************************************************
    logic [7:0] mem [0:4095];

    // cleared so write-backs never carry unknowns
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'h00;
        end
        dm_rd_data = 8'h00;
    end

    // read data stands one cycle, then turns to its inverse so stale use shows
    always @(posedge clk) begin
        if (dm_rd_en) begin
            dm_rd_data <= mem[dm_addr];
        end else begin
            dm_rd_data <= ~dm_rd_data;
        end
        if (dm_wr_en) begin
            mem[dm_addr] <= dm_wr_data;
        end
    end
endmodule

// >>> tb/tb_skip_test_and_xor_ops.sv
// self-checking bench for the skip-test / xor / table-write execute unit
// assumes the data memory model sxo_dmem and the design package are compiled first
module tb_skip_test_and_xor_ops;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0, next_two_word = 1'b0;
    logic ext_enable = 1'b0, ptr_load = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [3:0]  bank_select_reg = 4'h0;
    logic [11:0] index_base = 12'h000, dm_addr;
    logic [7:0]  dm_rd_data, table_latch = 8'h00, dm_wr_data, w_value, tbl_wr_data;
    logic [21:0] ptr_load_val = 22'h000000, tbl_wr_addr, table_pointer;
    logic instr_ready, instr_done, flush_prefetch, skip_active, dm_rd_en, dm_wr_en;
    logic flag_n, flag_z, tbl_wr_en;
    int n_mismatch = 0, compares = 0, cyc = 0, n_wr = 0, n_flush = 0, n_skip = 0;
    logic [11:0] last_wa;
    logic [21:0] last_ta;
    logic [7:0]  last_td;

    sxo_core u_sxo_core (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
        .instr_word(instr_word), .next_two_word(next_two_word),
        .bank_select_reg(bank_select_reg), .ext_enable(ext_enable),
        .index_base(index_base), .dm_rd_data(dm_rd_data), .table_latch(table_latch),
        .ptr_load(ptr_load), .ptr_load_val(ptr_load_val), .instr_ready(instr_ready),
        .instr_done(instr_done), .flush_prefetch(flush_prefetch),
        .skip_active(skip_active), .dm_addr(dm_addr), .dm_rd_en(dm_rd_en),
        .dm_wr_en(dm_wr_en), .dm_wr_data(dm_wr_data), .w_value(w_value),
        .flag_n(flag_n), .flag_z(flag_z), .tbl_wr_en(tbl_wr_en),
        .tbl_wr_addr(tbl_wr_addr), .tbl_wr_data(tbl_wr_data),
        .table_pointer(table_pointer));
    sxo_dmem u_sxo_dmem (.clk(clk), .dm_addr(dm_addr), .dm_rd_en(dm_rd_en),
        .dm_wr_en(dm_wr_en), .dm_wr_data(dm_wr_data), .dm_rd_data(dm_rd_data));

    // ************************************************************
    // clock, monitors, timeout
    // ************************************************************
    initial begin
        forever #2 clk = ~clk;
    end

    // write and flush traffic recorded so scenarios can judge side effects
    always @(posedge clk) begin
        cyc++;
        if (dm_wr_en === 1'b1) begin n_wr++; last_wa = dm_addr; end
        if (tbl_wr_en === 1'b1) begin last_ta = tbl_wr_addr; last_td = tbl_wr_data; end
        if (flush_prefetch === 1'b1) n_flush++;
        if (skip_active === 1'b1) n_skip++;
        if (cyc == 3000) begin n_mismatch++; report_and_stop(); end
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // offered while idle, then clocks counted from the taking edge to done
    task automatic issue(input logic [15:0] w, output int n);
        instr_word = w;
        instr_valid = 1'b1;
        @(posedge clk);
        #1 instr_valid = 1'b0;
        n = 0;
        while (instr_done !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1 n++;
        end
    endtask

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_xor_literal_op();
        int n;
        issue(16'h0ab5, n);
        chk("xor_literal_op cycles", 24'd4, n);
        chk("ready with done", 24'h1, instr_ready);
        chk("w", 24'hb5, w_value);
        chk("n set", 24'h1, flag_n);
        chk("z clear", 24'h0, flag_z);
        issue(16'h0ab5, n); // back to back
        chk("w zero", 24'h0, w_value);
        chk("z set", 24'h1, flag_z);
        chk("n clear", 24'h0, flag_n);
        $display("test xor_literal_op done");
    endtask

    task automatic t_xor_reg_op();
        int n;
        int w0;
        u_sxo_dmem.mem[12'h020] = 8'haf;
        u_sxo_dmem.mem[12'h310] = 8'hb5;
        issue(16'h0ab5, n);
        w0 = n_wr;
        issue(16'h1a20, n); // d=1 a=0
        chk("xor_reg_op cycles", 24'd4, n);
        chk("wr addr access", 24'h020, last_wa);
        chk("mem result", 24'h1a, u_sxo_dmem.mem[12'h020]);
        chk("w kept", 24'hb5, w_value);
        chk("z", 24'h0, flag_z);
        bank_select_reg = 4'h3;
        w0 = n_wr;
        issue(16'h1910, n); // d=0 a=1, banked
        chk("w dest", 24'h00, w_value);
        chk("no write", w0, n_wr);
        chk("z zero result", 24'h1, flag_z);
        issue(16'h1a90, n);
        chk("access high", 24'hf90, last_wa);
        ext_enable = 1'b1;
        index_base = 12'h400;
        issue(16'h1a5f, n);
        chk("indexed", 24'h45f, last_wa);
        issue(16'h1a60, n);
        chk("above limit", 24'h060, last_wa);
        ext_enable = 1'b0;
        $display("test xor_reg_op done");
    endtask

    task automatic t_tst();
        int n;
        int w0;
        int f0;
        int s0;
        u_sxo_dmem.mem[12'h030] = 8'h07;
        u_sxo_dmem.mem[12'h031] = 8'h00;
        u_sxo_dmem.mem[12'h331] = 8'h00;
        issue(16'h0a80, n); // w was 0: n set, z clear
        w0 = n_wr;
        f0 = n_flush;
        s0 = n_skip;
        issue(16'h6630, n);
        chk("tst nonzero cycles", 24'd4, n);
        chk("no flush", f0, n_flush);
        issue(16'h6631, n);
        chk("skip cycles", 24'd8, n);
        chk("flush once", f0 + 1, n_flush);
        chk("skip nop clocks", s0 + 4, n_skip);
        next_two_word = 1'b1;
        issue(16'h6731, n); // banked zero register
        chk("skip two-word cycles", 24'd12, n);
        chk("skip two-word nops", s0 + 12, n_skip);
        next_two_word = 1'b0;
        chk("n kept", 24'h1, flag_n);
        chk("z kept", 24'h0, flag_z);
        chk("tst no write", w0, n_wr);
        $display("test tst done");
    endtask

    task automatic load_ptr(input logic [21:0] v, input logic [7:0] lat);
        table_latch = lat;
        ptr_load_val = v;
        ptr_load = 1'b1;
        @(posedge clk);
        #1 ptr_load = 1'b0;
    endtask

    task automatic t_tbl();
        int n;
        load_ptr(22'h00a356, 8'h55);
        issue(16'h000d, n); // post-increment
        chk("tbl cycles", 24'd8, n);
        chk("post addr", 24'h00a356, last_ta);
        chk("post data", 24'h55, last_td);
        chk("post ptr", 24'h00a357, table_pointer);
        load_ptr(22'h01389a, 8'h34);
        issue(16'h000f, n); // pre-increment
        chk("pre addr", 24'h01389b, last_ta);
        chk("pre data", 24'h34, last_td);
        chk("pre ptr", 24'h01389b, table_pointer);
        $display("test table_write_op done");
    endtask

    // reset, then every scenario in turn
    initial begin
        repeat (4) @(posedge clk);
        chk("ready in reset", 24'h1, instr_ready);
        chk("w in reset", 24'h0, w_value);
        #1 sys_rst = 1'b0;
        t_xor_literal_op();
        t_xor_reg_op();
        t_tst();
        t_tbl();
        report_and_stop();
    end
endmodule
